// ==== rtl/cgs_defines.svh ====
// Constant macros for the compressed gap scheduler
`ifndef CGS_DEFINES_SVH
`define CGS_DEFINES_SVH
// Number of gap pattern sequences
`define CGS_NUM_SEQ 6
`define CGS_SEL_W 3
// Slots per frame, last slot index, discontinuous slots allowed per frame
`define CGS_SLOTS 10'h00f
`define CGS_LAST_SLOT 4'he
`define CGS_MAX_DTX 4'h7
// Field widths
`define CGS_FRAME_W 8
`define CGS_POW_W 8
// Reset values
`define CGS_CM_ON_RST 1'b1
`define CGS_SEL_RST 3'h0
`define CGS_POW_RST 8'h00
// Pin synchroniser length
`define CGS_SYNC_LEN 3
`endif

// ==== rtl/cgs_pkg.sv ====
// Types and shared arithmetic for the compressed gap scheduler
`include "cgs_defines.svh"
package cgs_pkg;
  typedef enum logic [1:0] {CGS_IDLE, CGS_WAIT, CGS_RUN, CGS_DONE} cgs_state_t;

  typedef struct packed {
    logic [7:0] pattern_start_frame;
    logic [3:0] gap_start_slot;
    logic [3:0] first_gap_length;
    logic [3:0] second_gap_length;
    logic [5:0] gap_distance;
    logic [5:0] first_pattern_length;
    logic [5:0] second_pattern_length;
    logic [7:0] pattern_repeat_count;
    logic active;
  } cgs_cfg_t;

  // Slot position falls inside a gap
  function automatic logic cgs_hit(input logic [9:0] pos, input logic [9:0] lo,
                                   input logic [9:0] len);
    return (pos >= lo) && (pos < 10'(lo + len));
  endfunction : cgs_hit

  // Gap touches any slot of the frame starting at base
  function automatic logic cgs_cover(input logic [9:0] base, input logic [9:0] lo,
                                     input logic [9:0] len);
    return (len != 10'h000) && (lo < 10'(base + `CGS_SLOTS)) && (10'(lo + len) > base);
  endfunction : cgs_cover
endpackage : cgs_pkg

// ==== rtl/cgs_seq_engine.sv ====
// One gap pattern sequence engine
`include "cgs_defines.svh"
module cgs_seq_engine import cgs_pkg::*; (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic run_i,
  input wire logic frame_end_i,
  input wire logic [7:0] conn_frame_i,
  input wire logic [3:0] slot_i,
  input wire logic [7:0] pattern_start_frame_i,
  input wire logic [3:0] gap_start_slot_i,
  input wire logic [3:0] first_gap_length_i,
  input wire logic [3:0] second_gap_length_i,
  input wire logic [5:0] gap_distance_i,
  input wire logic [5:0] first_pattern_length_i,
  input wire logic [5:0] second_pattern_length_i,
  input wire logic [7:0] pattern_repeat_count_i,
  input wire logic active_i,
  output logic comp_frame_o,
  output logic blank_o,
  output logic done_o
);
  cgs_state_t state;
  logic [5:0] fip;
  logic alt;
  logic [7:0] reps;
  logic framing;
  logic [5:0] cur_fip;
  logic [5:0] cur_pl;
  logic [9:0] base;
  logic [9:0] pos;
  logic [9:0] g1_lo;
  logic [9:0] g2_lo;
  logic last;
  logic finish;

  // Frame position inside the current pattern
  always_comb begin
    framing = run_i && active_i && (state == CGS_RUN ||
              (state == CGS_WAIT && conn_frame_i == pattern_start_frame_i));
    cur_fip = (state == CGS_RUN) ? fip : 6'h00;
    cur_pl = (alt && second_pattern_length_i != 6'h00) ? second_pattern_length_i
             : first_pattern_length_i;
    base = 10'(10'(cur_fip) * `CGS_SLOTS);
    pos = 10'(base + 10'(slot_i));
    g1_lo = 10'(gap_start_slot_i);
    g2_lo = 10'(10'(gap_start_slot_i) + 10'(gap_distance_i));
    last = 6'(cur_fip + 6'h01) >= cur_pl;
    finish = last && pattern_repeat_count_i != 8'h00 &&
             8'(reps + 8'h01) == pattern_repeat_count_i;
  end

  // Gaps may run past the frame end into the next frame
  assign comp_frame_o = framing && (cgs_cover(base, g1_lo, 10'(first_gap_length_i)) ||
                        cgs_cover(base, g2_lo, 10'(second_gap_length_i)));
  assign blank_o = framing && (cgs_hit(pos, g1_lo, 10'(first_gap_length_i)) ||
                   cgs_hit(pos, g2_lo, 10'(second_gap_length_i)));
  assign done_o = (state == CGS_DONE);

  // Sequence state
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= CGS_IDLE;
    end else if (!run_i || !active_i) begin
      state <= CGS_IDLE;
    end else begin
      case (state)
        CGS_IDLE: state <= CGS_WAIT;
        CGS_WAIT, CGS_RUN: begin
          if (frame_end_i && framing) begin
            state <= finish ? CGS_DONE : CGS_RUN;
          end
        end
        CGS_DONE: state <= CGS_DONE;
        default: state <= CGS_IDLE;
      endcase
    end
  end

  // Pattern frame, alternation and repeat counters
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fip <= 6'h00;
      alt <= 1'b0;
      reps <= 8'h00;
    end else if (!run_i || !active_i) begin
      fip <= 6'h00;
      alt <= 1'b0;
      reps <= 8'h00;
    end else if (frame_end_i && framing) begin
      if (last) begin
        fip <= 6'h00;
        alt <= (second_pattern_length_i != 6'h00) ? ~alt : 1'b0;
        reps <= 8'(reps + 8'h01);
      end else begin
        fip <= 6'(cur_fip + 6'h01);
      end
    end
  end

  idle_when_stopped_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    $fell(run_i) |-> ##1 (state == CGS_IDLE && fip == 6'h00 && !comp_frame_o))
    else $error("engine kept running after stop");
  repeat_done_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (frame_end_i && framing && finish && run_i) |=> (done_o && !comp_frame_o && !blank_o))
    else $error("engine did not stop after last repeat");
  wait_start_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (state == CGS_WAIT && conn_frame_i != pattern_start_frame_i) |-> !comp_frame_o && !blank_o)
    else $error("compressed frame before start frame");
endmodule : cgs_seq_engine

// ==== rtl/cgs_scheduler.sv ====
// Compressed gap scheduler top: settings, triggers and merged output
// Summary of operation
// - Six gap pattern sequences run side by side, each with own settings.
// - Timing settings are stored per sequence; only power offset is shared.
// - One power offset applies to every compressed frame of all sequences.
// - Two sequences compressing one frame: cancel trigger, send normal frames.
// - Without collision, compressed frames of all sequences merge in one stream.
// - Connection frame index counts frames from zero.
// - A sequence starts its first compressed frame at its start frame.
// - Fifteen slots per frame, at most seven blanked slots per frame.
// - One gap may span two consecutive frames.
// - Start slot gives where the first gap begins; earlier slots carry data.
// - First gap length counts blanked slots from the start slot.
// - Second gap length counts blanked slots of the second gap.
// - Gap distance spaces first gap start to second gap start in slots.
// - First pattern length sets the pattern duration in frames.
// - Optional second pattern length alternates with the first pattern.
// - Only active sequences emit compressed frames and join overlap checks.
// - Compressed mode enable resets on, selector resets to first sequence.
// - Marker output pulses for each compressed frame when selected.
// - Compressed frames wait for an external or operator start trigger.
// - External stop, operator stop or apply ends compressed transmission.
// - Finite repeat count stops sequence when used up; trigger clears once every active sequence is done.
// - Applying a new configuration clears the armed start trigger.
`include "cgs_defines.svh"
module cgs_scheduler import cgs_pkg::*; (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic slot_tick_i,
  input wire logic ext_start_i,
  input wire logic ext_stop_i,
  input wire logic op_start_i,
  input wire logic op_stop_i,
  input wire logic apply_i,
  input wire logic cm_on_we_i,
  input wire logic cm_on_i,
  input wire logic sel_we_i,
  input wire logic [2:0] gap_pattern_selector_i,
  input wire logic cfg_we_i,
  input wire logic [7:0] pattern_start_frame_i,
  input wire logic [3:0] gap_start_slot_i,
  input wire logic [3:0] first_gap_length_i,
  input wire logic [3:0] second_gap_length_i,
  input wire logic [5:0] gap_distance_i,
  input wire logic [5:0] first_pattern_length_i,
  input wire logic [5:0] second_pattern_length_i,
  input wire logic [7:0] pattern_repeat_count_i,
  input wire logic seq_active_i,
  input wire logic pow_we_i,
  input wire logic [7:0] compressed_power_offset_i,
  input wire logic compressed_frame_marker_select_i,
  output logic frame_compressed_o,
  output logic slot_blank_o,
  output logic marker_o,
  output logic [7:0] power_offset_o,
  output logic trig_active_o,
  output logic collision_o,
  output logic [7:0] connection_frame_index_o,
  output logic [3:0] slot_index_o,
  output logic [2:0] gap_pattern_selector_o,
  output logic cm_on_o,
  output logic [5:0] seq_done_o
);
  // Pending and running sets, one per sequence
  cgs_cfg_t shadow [`CGS_NUM_SEQ];
  cgs_cfg_t live [`CGS_NUM_SEQ];
  logic [7:0] compressed_power_offset;
  logic [`CGS_SYNC_LEN-1:0] sync_start;
  logic [`CGS_SYNC_LEN-1:0] sync_stop;
  logic lvl_start;
  logic lvl_stop;
  logic ext_start_pulse;
  logic ext_stop_pulse;
  logic frame_end;
  logic new_frame;
  logic [3:0] dtx_cnt;
  logic [5:0] comp_vec;
  logic [5:0] blank_vec;
  logic [5:0] done_vec;
  logic [5:0] act_vec;
  logic collide;
  logic all_done;
  logic start_any;
  logic clear_any;
  logic run;
  logic comp_any;
  logic blank_ok;

  // Pin synchronisers; a change counts once stages two and three agree
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_start <= '0;
      sync_stop <= '0;
      lvl_start <= 1'b0;
      lvl_stop <= 1'b0;
    end else begin
      sync_start <= {sync_start[1:0], ext_start_i};
      sync_stop <= {sync_stop[1:0], ext_stop_i};
      if (sync_start[1] == sync_start[2]) begin
        lvl_start <= sync_start[2];
      end
      if (sync_stop[1] == sync_stop[2]) begin
        lvl_stop <= sync_stop[2];
      end
    end
  end

  // One-cycle pulse on a settled rising edge
  assign ext_start_pulse = sync_start[1] && sync_start[2] && !lvl_start;
  assign ext_stop_pulse = sync_stop[1] && sync_stop[2] && !lvl_stop;

  // Slot and connection frame counters
  assign frame_end = slot_tick_i && (slot_index_o == `CGS_LAST_SLOT);

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      slot_index_o <= 4'h0;
      connection_frame_index_o <= 8'h00;
      new_frame <= 1'b0;
    end else begin
      new_frame <= frame_end;
      if (frame_end) begin
        slot_index_o <= 4'h0;
        connection_frame_index_o <= 8'(connection_frame_index_o + 8'h01);
      end else if (slot_tick_i) begin
        slot_index_o <= 4'(slot_index_o + 4'h1);
      end
    end
  end

  // Operator settings: enable, selector and shared power offset
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cm_on_o <= `CGS_CM_ON_RST;
      gap_pattern_selector_o <= `CGS_SEL_RST;
      compressed_power_offset <= `CGS_POW_RST;
    end else begin
      if (cm_on_we_i) begin
        cm_on_o <= cm_on_i;
      end
      if (sel_we_i && gap_pattern_selector_i < 3'(`CGS_NUM_SEQ)) begin
        gap_pattern_selector_o <= gap_pattern_selector_i;
      end
      if (pow_we_i) begin
        compressed_power_offset <= compressed_power_offset_i;
      end
    end
  end

  // Pending settings land only in the selected sequence
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < `CGS_NUM_SEQ; i++) begin
        shadow[i] <= '0;
      end
    end else if (cfg_we_i) begin
      shadow[gap_pattern_selector_o] <= {pattern_start_frame_i, gap_start_slot_i,
        first_gap_length_i, second_gap_length_i, gap_distance_i, first_pattern_length_i,
        second_pattern_length_i, pattern_repeat_count_i, seq_active_i};
    end
  end

  // Apply copies every pending set into the running sets
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < `CGS_NUM_SEQ; i++) begin
        live[i] <= '0;
      end
    end else if (apply_i) begin
      for (int i = 0; i < `CGS_NUM_SEQ; i++) begin
        live[i] <= shadow[i];
      end
    end
  end

  // Six sequence engines
  assign run = trig_active_o && cm_on_o;

  for (genvar g = 0; g < `CGS_NUM_SEQ; g++) begin : g_seq
    // Active flag of each running set
    assign act_vec[g] = live[g].active;
    cgs_seq_engine u_engine (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .run_i(run),
      .frame_end_i(frame_end),
      .conn_frame_i(connection_frame_index_o),
      .slot_i(slot_index_o),
      .pattern_start_frame_i(live[g].pattern_start_frame),
      .gap_start_slot_i(live[g].gap_start_slot),
      .first_gap_length_i(live[g].first_gap_length),
      .second_gap_length_i(live[g].second_gap_length),
      .gap_distance_i(live[g].gap_distance),
      .first_pattern_length_i(live[g].first_pattern_length),
      .second_pattern_length_i(live[g].second_pattern_length),
      .pattern_repeat_count_i(live[g].pattern_repeat_count),
      .active_i(live[g].active),
      .comp_frame_o(comp_vec[g]),
      .blank_o(blank_vec[g]),
      .done_o(done_vec[g])
    );
  end

  // Collision, completion and merged stream
  always_comb begin
    collide = $countones(comp_vec & act_vec) > 1;
    all_done = (|act_vec) && (&(done_vec | ~act_vec));
    start_any = (op_start_i || ext_start_pulse) && cm_on_o;
    clear_any = op_stop_i || ext_stop_pulse || apply_i || collide || all_done || !cm_on_o;
    comp_any = run && !collide && (|comp_vec);
    blank_ok = run && !collide && (|blank_vec) && (dtx_cnt < `CGS_MAX_DTX);
  end

  // Start trigger; a start wins over a clear in the same cycle
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trig_active_o <= 1'b0;
    end else if (start_any) begin
      trig_active_o <= 1'b1;
    end else if (clear_any) begin
      trig_active_o <= 1'b0;
    end
  end

  // Blanked slots counted per frame
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dtx_cnt <= 4'h0;
    end else if (frame_end) begin
      dtx_cnt <= 4'h0;
    end else if (slot_tick_i && blank_ok) begin
      dtx_cnt <= 4'(dtx_cnt + 4'h1);
    end
  end

  // Registered outputs
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frame_compressed_o <= 1'b0;
      slot_blank_o <= 1'b0;
      marker_o <= 1'b0;
      power_offset_o <= 8'h00;
      collision_o <= 1'b0;
      seq_done_o <= 6'h00;
    end else begin
      frame_compressed_o <= comp_any;
      slot_blank_o <= blank_ok;
      marker_o <= new_frame && comp_any && compressed_frame_marker_select_i;
      power_offset_o <= comp_any ? compressed_power_offset : 8'h00;
      collision_o <= collide;
      seq_done_o <= done_vec;
    end
  end

  // Trigger sources seen by the arming checks
  sequence s_ext_start;
    $rose(ext_start_i) ##1 ext_start_i [*3];
  endsequence
  sequence s_op_start;
    op_start_i && cm_on_o;
  endsequence

  // Overlap drops the trigger and the compressed frame
  collision_cancel_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (collide && !start_any) |=> !trig_active_o && !frame_compressed_o)
    else $error("collision did not cancel the trigger");

  // Operator start arms on the next edge
  op_start_arms_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    s_op_start |=> trig_active_o)
    else $error("operator start did not arm");

  // Pin start arms once the synchroniser agrees
  ext_start_arms_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (s_ext_start ##0 cm_on_o && !op_stop_i && !apply_i) |-> ##[0:1] trig_active_o)
    else $error("external start did not arm");

  // Apply disarms, normal frames follow
  apply_clears_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (apply_i && !start_any) |=> !trig_active_o ##1 !frame_compressed_o)
    else $error("apply left the trigger armed");

  // Frame end wraps the slot and advances the frame
  frame_wrap_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    frame_end |=> slot_index_o == 4'h0 &&
    connection_frame_index_o == 8'($past(connection_frame_index_o) + 8'h01))
    else $error("frame counter did not advance");

  // No blanked slot once the frame quota is used up
  dtx_limit_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (dtx_cnt >= `CGS_MAX_DTX) |=> !slot_blank_o)
    else $error("too many blanked slots in a frame");

  // Offset only on compressed frames
  power_offset_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    $past(comp_any) ? power_offset_o == $past(compressed_power_offset)
                    : power_offset_o == 8'h00)
    else $error("power offset wrong for frame type");

  // Marker only at a compressed frame
  marker_frame_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    marker_o |-> frame_compressed_o && $past(compressed_frame_marker_select_i))
    else $error("marker outside compressed frame");
endmodule : cgs_scheduler

// ==== dv/cgs_timing_model.sv ====
// Timing base and external trigger sources facing the scheduler
module cgs_timing_model #(
  parameter int TICK = 4
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  output logic slot_tick_o,
  output logic ext_start_o,
  output logic ext_stop_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;

  // One slot tick every TICK cycles, 15 of them make a frame
  initial begin
    slot_tick_o = 1'b0;
    ext_start_o = 1'b0;
    ext_stop_o = 1'b0;
  end
  always @(posedge mclk_i) begin
    #1;
    cnt = (!rstn_i || cnt == TICK - 1) ? 0 : cnt + 1;
    slot_tick_o = rstn_i && (cnt == TICK - 1);
  end

  // Start pin held high long enough to pass the synchroniser
  task automatic pulse_start();
    @(posedge mclk_i);
    #1 ext_start_o = 1'b1;
    repeat (4) @(posedge mclk_i);
    #1 ext_start_o = 1'b0;
  endtask : pulse_start

  // Stop pin driven the same way
  task automatic pulse_stop();
    @(posedge mclk_i);
    #1 ext_stop_o = 1'b1;
    repeat (4) @(posedge mclk_i);
    #1 ext_stop_o = 1'b0;
  endtask : pulse_stop
endmodule : cgs_timing_model

// ==== dv/test_compressed_gap_scheduler.sv ====
// Self-checking bench for the compressed gap scheduler
module test_compressed_gap_scheduler;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TICK = 4;
  localparam int LIMIT = 20000;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic slot_tick_i, ext_start_i, ext_stop_i;
  logic op_start_i = 0, op_stop_i = 0, apply_i = 0, cm_on_we_i = 0, cm_on_i = 1;
  logic sel_we_i = 0, cfg_we_i = 0, pow_we_i = 0, seq_active_i = 0, msel = 1;
  logic [2:0] sel_i = 3'h0;
  logic [7:0] psf = 8'h00, prc = 8'h00, pow_i = 8'h00;
  logic [3:0] pss = 4'h0, pg1 = 4'h0, pg2 = 4'h0;
  logic [5:0] pgd = 6'h00, pp1 = 6'h00, pp2 = 6'h00;
  logic frame_compressed_o, slot_blank_o, marker_o, trig_active_o, collision_o, cm_on_o;
  logic [7:0] power_offset_o, connection_frame_index_o, sf;
  logic [3:0] slot_index_o;
  logic [2:0] gap_pattern_selector_o;
  logic [5:0] seq_done_o;
  int miscompares = 0, tests_run = 0, cycles = 0, marks, blanks, badpow, coll, comps, n;
  logic [5:0] dones = 6'h00;
  logic en = 0;

  cgs_timing_model #(.TICK(TICK)) model (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .slot_tick_o(slot_tick_i), .ext_start_o(ext_start_i), .ext_stop_o(ext_stop_i));

  cgs_scheduler uut (.mclk_i(mclk_i), .rstn_i(rstn_i), .slot_tick_i(slot_tick_i),
    .ext_start_i(ext_start_i), .ext_stop_i(ext_stop_i), .op_start_i(op_start_i),
    .op_stop_i(op_stop_i), .apply_i(apply_i), .cm_on_we_i(cm_on_we_i), .cm_on_i(cm_on_i),
    .sel_we_i(sel_we_i), .gap_pattern_selector_i(sel_i), .cfg_we_i(cfg_we_i),
    .pattern_start_frame_i(psf), .gap_start_slot_i(pss), .first_gap_length_i(pg1),
    .second_gap_length_i(pg2), .gap_distance_i(pgd), .first_pattern_length_i(pp1),
    .second_pattern_length_i(pp2), .pattern_repeat_count_i(prc),
    .seq_active_i(seq_active_i), .pow_we_i(pow_we_i), .compressed_power_offset_i(pow_i),
    .compressed_frame_marker_select_i(msel), .frame_compressed_o(frame_compressed_o),
    .slot_blank_o(slot_blank_o), .marker_o(marker_o), .power_offset_o(power_offset_o),
    .trig_active_o(trig_active_o), .collision_o(collision_o),
    .connection_frame_index_o(connection_frame_index_o), .slot_index_o(slot_index_o),
    .gap_pattern_selector_o(gap_pattern_selector_o), .cm_on_o(cm_on_o),
    .seq_done_o(seq_done_o));

  // Clock at 200 MHz
  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  // Output monitor over a frame window, plus hang guard
  always @(posedge mclk_i) begin
    cycles++;
    if (en) begin
      marks += (marker_o === 1'b1);
      blanks += (slot_blank_o === 1'b1);
      badpow += (frame_compressed_o === 1'b1 && power_offset_o !== pow_i);
      coll += (collision_o === 1'b1);
      comps += (frame_compressed_o === 1'b1);
      dones = dones | seq_done_o;
    end
    if (cycles == LIMIT) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic step(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask : step

  // Select a sequence, then write its whole setting
  task automatic wr(input logic [2:0] s, input logic [7:0] f, input logic [3:0] ss,
                    input logic [3:0] g1, input logic [3:0] g2, input logic [5:0] gd,
                    input logic [5:0] p1, input logic [5:0] p2, input logic [7:0] rc);
    sel_we_i = 1; sel_i = s; step(1); sel_we_i = 0;
    psf = f; pss = ss; pg1 = g1; pg2 = g2; pgd = gd; pp1 = p1; pp2 = p2; prc = rc;
    seq_active_i = (g1 != 4'h0);
    cfg_we_i = 1; step(1); cfg_we_i = 0;
  endtask : wr

  // Deactivate every sequence and pick a start frame ahead
  task automatic prep();
    sf = connection_frame_index_o + 8'h04;
    for (int i = 0; i < 6; i++) wr(3'(i), 8'h00, 4'h0, 4'h0, 4'h0, 6'h00, 6'h00, 6'h00, 8'h00);
  endtask : prep

  task automatic apply_go();
    apply_i = 1; step(1); apply_i = 0; step(1);
    check(trig_active_o, 1'b0);
    op_start_i = 1; step(1); op_start_i = 0; step(1);
    check(trig_active_o, 1'b1);
  endtask : apply_go

  // Count markers and blanked slot cycles over a number of frames
  task automatic window(input logic [7:0] f, input int frames);
    n = 0;
    while (connection_frame_index_o !== f && n < 2000) begin step(1); n++; end
    marks = 0; blanks = 0; badpow = 0; coll = 0; comps = 0; dones = 6'h00; en = 1;
    step(frames * 15 * TICK);
    en = 0;
  endtask : window

  initial begin
    step(2);
    rstn_i = 1;
    check({cm_on_o, gap_pattern_selector_o, trig_active_o}, 16'h0010);
    check(connection_frame_index_o, 16'h0000);
    window(8'h01, 0);
    n = 0;
    while (connection_frame_index_o === 8'h01 && n < 200) begin step(1); n++; end
    check(16'(n), 16'(15 * TICK));
    check(slot_index_o, 16'h0000);
    sel_we_i = 1; sel_i = 3'h2; step(1); sel_i = 3'h6; step(1); sel_we_i = 0; step(1);
    check(gap_pattern_selector_o, 16'h0002);
    // Two sequences interleaved, second gap and shared power offset
    prep();
    wr(3'h0, sf, 4'h5, 4'h5, 4'h3, 6'h1e, 6'h05, 6'h00, 8'h00);
    wr(3'h5, sf + 8'h01, 4'h3, 4'h7, 4'h0, 6'h00, 6'h05, 6'h00, 8'h00);
    pow_i = 8'h06; pow_we_i = 1; step(1); pow_we_i = 0;
    apply_go();
    window(sf, 20);
    check(16'(marks), 16'd12);
    check(16'(blanks), 16'(60 * TICK));
    check(16'(badpow), 16'h0000);
    check(16'(coll), 16'h0000);
    check(16'(comps), 16'(12 * 15 * TICK));
    msel = 0;
    window(sf + 8'h14, 10);
    check(16'(marks), 16'h0000);
    check(16'(blanks), 16'(30 * TICK));
    msel = 1;
    // Gap spilling over two frames, two patterns only
    prep();
    wr(3'h2, sf, 4'h8, 4'he, 4'h0, 6'h00, 6'h05, 6'h00, 8'h02);
    apply_go();
    window(sf, 20);
    check(16'(marks), 16'h0004);
    check(16'(comps), 16'(4 * 15 * TICK));
    check(16'(blanks), 16'(28 * TICK));
    check({dones[2], trig_active_o}, 16'h0002);
    // Alternating pattern lengths
    prep();
    wr(3'h3, sf, 4'h0, 4'h2, 4'h0, 6'h00, 6'h02, 6'h03, 8'h00);
    apply_go();
    window(sf, 20);
    check(16'(marks), 16'h0008);
    check(16'(comps), 16'(8 * 15 * TICK));
    check(16'(blanks), 16'(16 * TICK));
    // Two sequences compressing the same frame
    prep();
    wr(3'h0, sf, 4'h0, 4'h2, 4'h0, 6'h00, 6'h05, 6'h00, 8'h00);
    wr(3'h1, sf, 4'h9, 4'h2, 4'h0, 6'h00, 6'h05, 6'h00, 8'h00);
    apply_go();
    window(sf, 10);
    check(16'(marks), 16'h0000);
    check({15'(coll != 0), trig_active_o}, 16'h0002);
    check(16'(comps), 16'h0000);
    // Trigger sources and refusal while compressed mode is off
    model.pulse_start();
    step(6);
    check(trig_active_o, 1'b1);
    model.pulse_stop();
    step(6);
    check(trig_active_o, 1'b0);
    op_start_i = 1; step(1); op_start_i = 0; op_stop_i = 1; step(1); op_stop_i = 0; step(1);
    check(trig_active_o, 1'b0);
    cm_on_we_i = 1; cm_on_i = 0; step(1); cm_on_we_i = 0;
    op_start_i = 1; step(1); op_start_i = 0; step(1);
    check({cm_on_o, trig_active_o}, 16'h0000);
    stop_test();
  end
endmodule : test_compressed_gap_scheduler
